// ---- logic/sdbpt_timer.sv ----
// split dual byte pwm timer: two down counters with four pwm compares each
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
module sdbpt_timer
   import sdbpt_pkg::*;
#(
   parameter int PRESC_W = 10
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire sdbpt_bus_req_t bus_i,
   output logic [DATA_W-1:0] rdata_o,
   input wire logic ev_clk_i,
   input wire logic ev_ctl_i,
   output logic [2*NCH-1:0] pwm_o,
   output logic [NCH-1:0] cmp_ev_o,
   output logic [NCH-1:0] dma_trig_o,
   output logic lunf_ev_o,
   output logic hunf_ev_o,
   output logic irq_o
);
   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] ctrl_ff;
   logic [DATA_W-1:0] evctrl_ff;
   logic [DATA_W-1:0] status_ff;
   logic [DATA_W-1:0] mask_ff;
   logic [DATA_W-1:0] lper_ff;
   logic [DATA_W-1:0] hper_ff;
   logic [DATA_W-1:0] lcnt_ff;
   logic [DATA_W-1:0] hcnt_ff;
   logic [DATA_W-1:0] cmp_ff [2*NCH];
   logic [DATA_W-1:0] rdata_ff;
   logic [DATA_W-1:0] nxt_rdata;
   logic [2:0] clk_sel;
   logic split_on;
   logic ev_en;
   sdbpt_evact_t ev_act;
   logic wr_lcnt;
   logic wr_hcnt;
   logic rd_status;

   assign split_on = ctrl_ff[CTRL_SPLIT_BIT];
   assign clk_sel = ctrl_ff[CTRL_CLK_LSB +: 3];
   assign ev_en = evctrl_ff[EV_EN_BIT];
   assign ev_act = sdbpt_evact_t'(evctrl_ff[EV_ACT_LSB +: 2]);
   assign wr_lcnt = bus_i.wr && (bus_i.addr == ADDR_LCNT);
   assign wr_hcnt = bus_i.wr && (bus_i.addr == ADDR_HCNT);
   assign rd_status = bus_i.rd && (bus_i.addr == ADDR_STATUS);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_ff <= CTRL_RST;
         evctrl_ff <= CTRL_RST;
         mask_ff <= ZERO8;
         lper_ff <= PER_RST;
         hper_ff <= PER_RST;
      end else if (ce_i && bus_i.wr) begin
         unique case (bus_i.addr)
            ADDR_CTRL: ctrl_ff <= bus_i.wdata;
            ADDR_EVCTRL: evctrl_ff <= bus_i.wdata;
            ADDR_MASK: mask_ff <= bus_i.wdata;
            ADDR_LPER: lper_ff <= bus_i.wdata;
            ADDR_HPER: hper_ff <= bus_i.wdata;
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // compare registers
   // ---------------------------------------------------------------
   // separate compares
   genvar gi;
   generate
      for (gi = 0; gi < 2*NCH; gi++) begin : g_cmp
         localparam logic [ADDR_W-1:0] CA = ADDR_W'(int'(ADDR_CMP_BASE) + gi*ADDR_CMP_STEP);
         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               cmp_ff[gi] <= CMP_RST;
            end else if (ce_i && bus_i.wr && bus_i.addr == CA) begin
               cmp_ff[gi] <= bus_i.wdata;
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // event input synchronisers
   // ---------------------------------------------------------------
   logic [1:0] evclk_sync_ff;
   logic [1:0] evctl_sync_ff;
   logic evclk_d_ff;
   logic evctl_d_ff;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         evclk_sync_ff <= 2'h0;
         evctl_sync_ff <= 2'h0;
         evclk_d_ff <= 1'b0;
         evctl_d_ff <= 1'b0;
      end else if (ce_i) begin
         evclk_sync_ff <= {evclk_sync_ff[0], ev_clk_i};
         evctl_sync_ff <= {evctl_sync_ff[0], ev_ctl_i};
         evclk_d_ff <= evclk_sync_ff[1];
         evctl_d_ff <= evctl_sync_ff[1];
      end
   end

   // ---------------------------------------------------------------
   // shared count tick
   // ---------------------------------------------------------------
   logic [PRESC_W-1:0] presc_ff;
   logic tick;
   logic src_tick;
   logic ev_rise;
   logic ev_restart;
   logic ev_stall;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         presc_ff <= '0;
      end else if (ce_i) begin
         presc_ff <= presc_ff + PRESC_W'(1);
      end
   end

   always_comb begin
      unique case (clk_sel)
         CLK_OFF: src_tick = 1'b0;
         CLK_EVENT: src_tick = evclk_sync_ff[1] && !evclk_d_ff;
         default: src_tick = (presc_ff & PRESC_W'((1 << (2*(clk_sel - 3'h1))) - 1)) == '0;
      endcase
   end

   assign ev_rise = evctl_sync_ff[1] && !evctl_d_ff;
   assign ev_restart = ev_en && (ev_act == SDBPT_EV_RESTART) && ev_rise;
   assign ev_stall = ev_en && (((ev_act == SDBPT_EV_HOLD) && evctl_sync_ff[1])
                     || ((ev_act == SDBPT_EV_GATE) && !evctl_sync_ff[1]));
   assign tick = split_on && src_tick && !ev_stall;

   // ---------------------------------------------------------------
   // counters
   // ---------------------------------------------------------------
   logic lunf;
   logic hunf;
   assign lunf = tick && (lcnt_ff == ZERO8);
   assign hunf = tick && (hcnt_ff == ZERO8);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         lcnt_ff <= ZERO8;
         hcnt_ff <= ZERO8;
      end else if (ce_i) begin
         if (wr_lcnt) begin
            lcnt_ff <= bus_i.wdata;
         end else if (ev_restart || lunf) begin
            lcnt_ff <= lper_ff;
         end else if (tick) begin
            lcnt_ff <= lcnt_ff - 8'h01;
         end
         if (wr_hcnt) begin
            hcnt_ff <= bus_i.wdata;
         end else if (ev_restart || hunf) begin
            hcnt_ff <= hper_ff;
         end else if (tick) begin
            hcnt_ff <= hcnt_ff - 8'h01;
         end
      end
   end

   // ---------------------------------------------------------------
   // pwm and compare events
   // ---------------------------------------------------------------
   logic [NCH-1:0] lmatch;
   logic [2*NCH-1:0] nxt_pwm;
   generate
      for (gi = 0; gi < 2*NCH; gi++) begin : g_pwm
         logic [DATA_W-1:0] cnt;
         assign cnt = (gi < NCH) ? lcnt_ff : hcnt_ff;
         assign nxt_pwm[gi] = split_on && (cnt < cmp_ff[gi]);
      end
      for (gi = 0; gi < NCH; gi++) begin : g_lm
         assign lmatch[gi] = tick && (lcnt_ff == cmp_ff[gi]);
      end
   endgenerate

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pwm_o <= '0;
      end else if (ce_i) begin
         pwm_o <= nxt_pwm;
      end
   end

   // ---------------------------------------------------------------
   // event and dma outputs
   // ---------------------------------------------------------------
   // events and dma triggers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cmp_ev_o <= '0;
         dma_trig_o <= '0;
         lunf_ev_o <= 1'b0;
         hunf_ev_o <= 1'b0;
      end else if (ce_i) begin
         cmp_ev_o <= lmatch;
         dma_trig_o <= lmatch;
         lunf_ev_o <= lunf;
         hunf_ev_o <= hunf;
      end
   end

   // ---------------------------------------------------------------
   // status and interrupt
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] events;
   logic [DATA_W-1:0] nxt_status;
   logic nxt_irq;
   assign events = {(DATA_W-NCH-2)'(0), lmatch, hunf, lunf};
   assign nxt_status = (rd_status ? ZERO8 : status_ff) | events;
   assign nxt_irq = |(nxt_status & mask_ff);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         status_ff <= ZERO8;
      end else if (ce_i) begin
         status_ff <= nxt_status;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else if (ce_i) begin
         irq_o <= nxt_irq;
      end
   end

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   always_comb begin
      nxt_rdata = ZERO8;
      if (bus_i.rd) begin
         unique case (bus_i.addr)
            ADDR_CTRL: nxt_rdata = ctrl_ff;
            ADDR_EVCTRL: nxt_rdata = evctrl_ff;
            ADDR_STATUS: nxt_rdata = status_ff;
            ADDR_MASK: nxt_rdata = mask_ff;
            ADDR_LPER: nxt_rdata = lper_ff;
            ADDR_HPER: nxt_rdata = hper_ff;
            ADDR_LCNT: nxt_rdata = lcnt_ff;
            ADDR_HCNT: nxt_rdata = hcnt_ff;
            default: begin
               for (int i = 0; i < 2*NCH; i++) begin
                  if (bus_i.addr == ADDR_W'(int'(ADDR_CMP_BASE) + i*ADDR_CMP_STEP)) begin
                     nxt_rdata = cmp_ff[i];
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_ff <= ZERO8;
      end else if (ce_i) begin
         rdata_ff <= nxt_rdata;
      end
   end
   assign rdata_o = rdata_ff;
endmodule // sdbpt_timer

// ---- shared/sdbpt_pkg.sv ----
// constants and types for the split dual byte pwm timer
package sdbpt_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_EVCTRL = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_MASK = 8'h0c;
   localparam logic [7:0] ADDR_LPER = 8'h10;
   localparam logic [7:0] ADDR_HPER = 8'h14;
   localparam logic [7:0] ADDR_LCNT = 8'h18;
   localparam logic [7:0] ADDR_HCNT = 8'h1c;
   localparam logic [7:0] ADDR_CMP_BASE = 8'h20;
   localparam int ADDR_CMP_STEP = 4;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int NCH = 4;
   // ---------------------------------------------------------------
   // ctrl fields: [0] split, [3:1] clock select
   // ---------------------------------------------------------------
   localparam int CTRL_SPLIT_BIT = 0;
   localparam int CTRL_CLK_LSB = 1;
   localparam logic [2:0] CLK_OFF = 3'h0;
   localparam logic [2:0] CLK_EVENT = 3'h7;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // ev ctrl: [0] enable, [2:1] action
   localparam int EV_EN_BIT = 0;
   localparam int EV_ACT_LSB = 1;
   // ---------------------------------------------------------------
   // status bits
   // ---------------------------------------------------------------
   localparam int ST_LUNF = 0;
   localparam int ST_HUNF = 1;
   localparam int ST_CMP_LSB = 2;
   localparam logic [7:0] PER_RST = 8'hff;
   localparam logic [7:0] CMP_RST = 8'h00;
   localparam logic [7:0] ZERO8 = 8'h00;

   typedef enum logic [1:0] {
      SDBPT_EV_NONE = 2'h0,
      SDBPT_EV_RESTART = 2'h1,
      SDBPT_EV_HOLD = 2'h2,
      SDBPT_EV_GATE = 2'h3
   } sdbpt_evact_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } sdbpt_bus_req_t;
endpackage

// ---- verif/sdbpt_evsys_model.sv ----
// event source and dma trigger counter facing the split timer
`timescale 1ns/10ps
module sdbpt_evsys_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [7:0] n_i,
   input wire logic hold_i,
   input wire logic [3:0] trig_i,
   output logic ev_clk_o,
   output logic ev_ctl_o,
   output logic [7:0] trig_cnt_o
);
   logic [7:0] left_ff;
   logic [1:0] ph_ff;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         left_ff <= 8'h00;
         ph_ff <= 2'h0;
         ev_clk_o <= 1'b0;
      end else begin
         if (start_i) begin
            left_ff <= n_i;
            ph_ff <= 2'h0;
         end else if (left_ff != 8'h00) begin
            ph_ff <= ph_ff + 2'h1;
            if (ph_ff == 2'h3) left_ff <= left_ff - 8'h01;
         end
         ev_clk_o <= (left_ff != 8'h00) && !ph_ff[1];
      end
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) ev_ctl_o <= 1'b0;
      else ev_ctl_o <= hold_i;
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) trig_cnt_o <= 8'h00;
      else trig_cnt_o <= trig_cnt_o + 8'($countones(trig_i));
   end
endmodule // sdbpt_evsys_model

// ---- verif/sdbpt_timer_properties.sv ----
// assertion checker for the split dual byte pwm timer
`timescale 1ns/10ps
module sdbpt_checker
   import sdbpt_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire sdbpt_bus_req_t bus_i,
   input wire logic [DATA_W-1:0] rdata_o,
   input wire logic ev_clk_i,
   input wire logic ev_ctl_i,
   input wire logic [2*NCH-1:0] pwm_o,
   input wire logic [NCH-1:0] cmp_ev_o,
   input wire logic [NCH-1:0] dma_trig_o,
   input wire logic lunf_ev_o,
   input wire logic hunf_ev_o,
   input wire logic irq_o
);
   // ---------------------------------------------------------------
   // shadow state and properties
   // ---------------------------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [3:0] ctrl_ff;
   logic mzero_ff;
   logic [2:0] off_ff;
   logic [2:0] evl_ff;
   logic [2:0] mz_ff;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) ctrl_ff <= 4'h0;
      else if (ce_i && bus_i.wr && bus_i.addr == ADDR_CTRL) ctrl_ff <= bus_i.wdata[3:0];
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) mzero_ff <= 1'b0;
      else if (ce_i && bus_i.wr && bus_i.addr == ADDR_MASK) mzero_ff <= (bus_i.wdata == ZERO8);
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) off_ff <= 3'h0;
      else if (ctrl_ff[0] && ctrl_ff[3:1] != CLK_OFF) off_ff <= 3'h0;
      else if (ce_i && off_ff != 3'h7) off_ff <= off_ff + 3'h1;
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) evl_ff <= 3'h0;
      else if (ev_clk_i || ctrl_ff != {CLK_EVENT, 1'b1}) evl_ff <= 3'h0;
      else if (ce_i && evl_ff != 3'h7) evl_ff <= evl_ff + 3'h1;
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) mz_ff <= 3'h0;
      else if (!mzero_ff) mz_ff <= 3'h0;
      else if (ce_i && mz_ff != 3'h7) mz_ff <= mz_ff + 3'h1;
   end
   sequence s_quiet;
      !lunf_ev_o && !hunf_ev_o && cmp_ev_o == 4'h0;
   endsequence
   sequence s_rd_unmapped;
      ce_i && bus_i.rd && bus_i.addr >= 8'h40;
   endsequence
   AST_RESET_QUIET: assert property ($fell(rst_i) |-> pwm_o == 8'h00 && !irq_o ##0 s_quiet)
      else $error("outputs active after reset");
   AST_OFF_QUIET: assert property (off_ff >= 3'h4 |-> s_quiet)
      else $error("events while timer stopped");
   AST_EV_IDLE_QUIET: assert property (evl_ff == 3'h7 |-> s_quiet)
      else $error("events without event clock edge");
   AST_DMA_MIRRORS: assert property (dma_trig_o == cmp_ev_o)
      else $error("dma trigger differs from compare event");
   AST_MASK_SILENCES: assert property (mz_ff >= 3'h3 |-> !irq_o)
      else $error("interrupt with empty mask");
   AST_RDATA_IDLE: assert property ($past(ce_i) && !$past(bus_i.rd) |-> rdata_o == ZERO8)
      else $error("read data outside read slot");
   AST_UNMAPPED_ZERO: assert property (s_rd_unmapped |=> rdata_o == ZERO8)
      else $error("unmapped read not zero");
   AST_CE_FREEZE: assert property (!ce_i |=> $stable(pwm_o) && $stable(irq_o) && $stable(lunf_ev_o))
      else $error("state moved with enable low");
endmodule // sdbpt_checker
bind sdbpt_timer sdbpt_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .bus_i(bus_i), .rdata_o(rdata_o),
   .ev_clk_i(ev_clk_i), .ev_ctl_i(ev_ctl_i), .pwm_o(pwm_o), .cmp_ev_o(cmp_ev_o), .dma_trig_o(dma_trig_o),
   .lunf_ev_o(lunf_ev_o), .hunf_ev_o(hunf_ev_o), .irq_o(irq_o));

// ---- verif/testbench.sv ----
// self-checking testbench for the split dual byte pwm timer
`timescale 1ns/10ps
module testbench;
   import sdbpt_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i;
   logic ce_i = 1'b1;
   sdbpt_bus_req_t bus_i = '0;
   logic [7:0] rdata_o, d, t0, trig_n;
   logic [7:0] npulse = 8'h00;
   logic [7:0] pwm_o;
   logic [3:0] cmp_ev_o, dma_trig_o;
   logic lunf_ev_o, hunf_ev_o, irq_o, ev_clk_i, ev_ctl_i;
   logic hold = 1'b0;
   logic go = 1'b0;
   int errors = 0;
   int n_checks = 0;
   int cyc = 0;
   int cnt[14] = '{default: 0};
   int base[14];
   // ---------------------------------------------------------------
   // clock, design, partner, counters
   // ---------------------------------------------------------------
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   sdbpt_timer dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .bus_i(bus_i), .rdata_o(rdata_o), .ev_clk_i(ev_clk_i),
      .ev_ctl_i(ev_ctl_i), .pwm_o(pwm_o), .cmp_ev_o(cmp_ev_o), .dma_trig_o(dma_trig_o), .lunf_ev_o(lunf_ev_o),
      .hunf_ev_o(hunf_ev_o), .irq_o(irq_o));
   sdbpt_evsys_model evs (.clk_i(clk_i), .rst_i(rst_i), .start_i(go), .n_i(npulse), .hold_i(hold),
      .trig_i(dma_trig_o), .ev_clk_o(ev_clk_i), .ev_ctl_o(ev_ctl_i), .trig_cnt_o(trig_n));
   always @(posedge clk_i) begin
      for (int i = 0; i < 8; i++) cnt[i] += int'(pwm_o[i]);
      for (int i = 0; i < 4; i++) cnt[8+i] += int'(cmp_ev_o[i]);
      cnt[12] += int'(lunf_ev_o);
      cnt[13] += int'(hunf_ev_o);
      cyc++;
      if (cyc == 5000) begin
         errors++;
         print_verdict();
      end
   end
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_i);
      bus_i <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      bus_i <= '0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      bus_i <= '0;
      #1;
      d = rdata_o;
      if (exp !== 8'hxx) check(d, exp);
   endtask
   task automatic window(input int n);
      base = cnt;
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   function automatic logic [7:0] dl(input int k);
      return 8'(cnt[k] - base[k]);
   endfunction
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial begin
      rst_i = 1'b1;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(ADDR_CTRL, CTRL_RST);
      rd(ADDR_LPER, PER_RST);
      rd(ADDR_CMP_BASE, CMP_RST);
      rd(8'h44, ZERO8);
      $display("test reset done");
      wr(ADDR_LPER, 8'h05);
      wr(ADDR_HPER, 8'h03);
      wr(ADDR_CTRL, 8'h03);
      window(4);
      window(24);
      check(dl(12), 8'h04);
      check(dl(13), 8'h06);
      $display("test periods done");
      wr(ADDR_HPER, 8'h05);
      for (int i = 0; i < 8; i++) wr(ADDR_CMP_BASE + 8'(ADDR_CMP_STEP * i), 8'(i % 4 + 1));
      window(8);
      t0 = trig_n;
      window(6);
      for (int i = 0; i < 8; i++) check(dl(i), 8'(i % 4 + 1));
      for (int i = 0; i < 4; i++) check(dl(8 + i), 8'h01);
      check(trig_n - t0, 8'h04);
      $display("test pwm done");
      wr(ADDR_MASK, 8'h01);
      window(8);
      check({7'h0, irq_o}, 8'h01);
      rd(ADDR_STATUS, 8'h3f);
      wr(ADDR_MASK, 8'h00);
      window(4);
      check({7'h0, irq_o}, 8'h00);
      $display("test irq done");
      wr(ADDR_EVCTRL, 8'h05);
      hold <= 1'b1;
      window(6);
      window(20);
      check(dl(12), 8'h00);
      hold <= 1'b0;
      wr(ADDR_EVCTRL, 8'h07);
      window(6);
      window(20);
      check(dl(12), 8'h00);
      wr(ADDR_EVCTRL, 8'h00);
      wr(ADDR_CTRL, 8'h0f);
      wr(ADDR_LCNT, 8'h02);
      wr(ADDR_HCNT, 8'h05);
      npulse <= 8'h03;
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      window(30);
      check(dl(12), 8'h01);
      check(dl(13), 8'h00);
      wr(ADDR_LCNT, 8'h02);
      wr(ADDR_EVCTRL, 8'h03);
      hold <= 1'b1;
      window(6);
      rd(ADDR_LCNT, 8'h05);
      rd(ADDR_HCNT, 8'h05);
      hold <= 1'b0;
      wr(ADDR_EVCTRL, 8'h00);
      $display("test events done");
      wr(ADDR_CTRL, 8'h05);
      window(30);
      window(48);
      check(dl(12), 8'h02);
      check(dl(13), 8'h02);
      $display("test prescale done");
      @(posedge clk_i);
      ce_i <= 1'b0;
      wr(ADDR_LPER, 8'h11);
      @(posedge clk_i);
      ce_i <= 1'b1;
      rd(ADDR_LPER, 8'h05);
      wr(ADDR_CTRL, 8'h02);
      window(10);
      window(20);
      check(dl(12) | dl(13) | dl(8), 8'h00);
      $display("test stop done");
      print_verdict();
   end
endmodule // testbench
